// ==== hw/arc_out_relay.sv ====
// Purpose: One trip output relay with programmable reset time and latch
// Assumes: tick from arc_tick_gen
// Notes:   Latched relay drops only on reset_all once the drive is gone
`timescale 1ns/1ps
module arc_out_relay
   import arc_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire logic          tick,
   // Control
   input  wire logic          drive,
   input  wire logic          latch_en,
   input  wire logic          reset_all,
   input  wire logic [TMR_W-1:0] reset_time,
   // Relay
   output logic               relay_on
);

   logic [TMR_W-1:0] hold_reg;
   logic          latched_reg;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         relay_on    <= 1'b0;
         latched_reg <= 1'b0;
         hold_reg    <= '0;
      end
      else if (drive)
      begin
         relay_on    <= 1'b1;
         latched_reg <= latch_en;
         hold_reg    <= '0;
      end
      else if (relay_on && latched_reg)
      begin
         if (reset_all)
         begin
            relay_on    <= 1'b0;
            latched_reg <= 1'b0;
         end
      end
      else if (relay_on)
      begin
         if (hold_reg >= reset_time)
            relay_on <= 1'b0;
         else if (tick)
            hold_reg <= hold_reg + 16'h1;
      end
   end

endmodule : arc_out_relay

// ==== hw/arc_pkg.sv ====
// Purpose: Shared constants and types for the autoreclose sequencer
// Assumes: 100 MHz clk_sys, 10 ms protection timing tick
// Notes:   Timer settings are held in ticks, 16 bits wide
package arc_pkg;

   // Clock and tick
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TICK_PERIOD_NS = 10_000_000;
   localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_MS        = TICK_PERIOD_NS / 1_000_000;

   // Sizes
   localparam int AW     = 8;
   localparam int DW     = 32;
   localparam int TMR_W  = 16;
   localparam int N_SRC  = 13;
   localparam int N_PROT = 12;
   localparam int N_RLY  = 7;
   localparam int N_TMR  = 11;
   localparam int N_PIN  = 10;

   // Register offsets (byte addresses)
   localparam logic [AW-1:0] OFS_CTRL  = 8'h00;
   localparam logic [AW-1:0] OFS_INIT  = 8'h04;
   localparam logic [AW-1:0] OFS_STAT  = 8'h08;
   localparam logic [AW-1:0] OFS_LATCH = 8'h0c;
   localparam logic [AW-1:0] OFS_TMR   = 8'h10;
   localparam logic [AW-1:0] OFS_RLY   = 8'h40;

   // Control fields
   localparam int CTRL_EN      = 0;
   localparam int CTRL_NUM_LSB = 1;
   localparam int CTRL_CO_PH   = 4;
   localparam int CTRL_CO_EF   = 5;
   localparam int CTRL_CO_SE   = 6;
   localparam logic [DW-1:0] CTRL_RST  = 32'h0000_0001;
   localparam logic [DW-1:0] INIT_RST  = 32'h0000_0001;
   localparam logic [DW-1:0] LATCH_RST = 32'h0000_0000;
   localparam logic [2:0]    NUM_MAX   = 3'h4;

   // Initiation selector codes
   localparam logic [1:0] SEL_NA  = 2'h0;
   localparam logic [1:0] SEL_A1  = 2'h1;
   localparam logic [1:0] SEL_A2  = 2'h2;
   localparam logic [1:0] SEL_BLK = 2'h3;

   // Status fields
   localparam int STAT_STEP = 0;
   localparam int STAT_FT   = 5;
   localparam int STAT_RDY  = 6;
   localparam int STAT_ACT  = 7;
   localparam int STAT_SHOT = 8;

   // Timer slots
   localparam int T_RECLAIM = 0;
   localparam int T_DEAD1   = 1;
   localparam int T_PULSE   = 6;
   localparam int T_SUCC    = 7;
   localparam int T_RECOV   = 8;
   localparam int T_PAUSE   = 9;
   localparam int T_SRESET  = 10;

   // Default times in ms
   localparam int RECLAIM_MS = 60000;
   localparam int DEAD_MS    = 10000;
   localparam int PULSE_MS   = 2000;
   localparam int SUCC_MS    = 3000;
   localparam int RECOV_MS   = 10000;
   localparam int PAUSE_MS   = 10000;
   localparam int SRESET_MS  = 3000;

   localparam logic [TMR_W-1:0] TMR_DEF [N_TMR] = '{
      16'(RECLAIM_MS / TICK_MS), 16'(DEAD_MS / TICK_MS), 16'(DEAD_MS / TICK_MS),
      16'(DEAD_MS / TICK_MS), 16'(DEAD_MS / TICK_MS), 16'(DEAD_MS / TICK_MS),
      16'(PULSE_MS / TICK_MS), 16'(SUCC_MS / TICK_MS), 16'(RECOV_MS / TICK_MS),
      16'(PAUSE_MS / TICK_MS), 16'(SRESET_MS / TICK_MS)};
   localparam logic [TMR_W-1:0] RLY_DEF = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE, ST_READY, ST_DEAD, ST_PULSE, ST_JUDGE, ST_SRESET, ST_FINAL, ST_PAUSE
   } arc_state_t;

endpackage : arc_pkg

// ==== hw/arc_sequencer.sv ====
// Purpose: Multi-shot autoreclose sequencer with trip output relays
// Assumes: Binary inputs are asynchronous pins; protection trips and
//          current level flags come from logic on clk_sys
// Notes:   All timer settings count 10 ms ticks
`timescale 1ns/1ps
module arc_sequencer
   import arc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // Register port
   input  wire logic [AW-1:0]     reg_addr,
   input  wire logic [DW-1:0]     reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DW-1:0]     reg_rdata,
   // Protection elements
   input  wire logic [N_PROT-1:0] prot_trip,
   input  wire logic [N_RLY-1:0]  relay_drive,
   input  wire logic              phase_over,
   input  wire logic              earth_over,
   input  wire logic              sens_earth_over,
   // Binary inputs
   input  wire logic [2:0]        ext_phase_trip,
   input  wire logic              external_three_phase_trip,
   input  wire logic              reclose_block_input,
   input  wire logic              breaker_ready,
   input  wire logic              breaker_closed,
   input  wire logic              manual_close,
   input  wire logic              reset_key,
   input  wire logic              remote_reset,
   // Outputs
   output logic [N_RLY-1:0]       relay_out,
   output logic                   reclose_command,
   output logic                   final_trip_flag,
   output logic                   step_bit_one,
   output logic                   step_bit_two,
   output logic                   step_bit_three,
   output logic                   step_bit_four,
   output logic                   step_bit_five,
   output logic                   reclose_ready
);

   // Settings
   logic [DW-1:0] ctrl_reg;
   logic [DW-1:0] init_reg;
   logic [DW-1:0] latch_reg;
   logic [TMR_W-1:0] tmr_reg [N_TMR];
   logic [TMR_W-1:0] rly_reg [N_RLY];

   // Pin synchronisers
   logic [N_PIN-1:0] pin_raw;
   logic [N_PIN-1:0] pin_m_reg;
   logic [N_PIN-1:0] pin_s_reg;

   // Sequencer state
   arc_state_t    st_reg;
   arc_state_t    st_next;
   logic [2:0]    shot_reg;
   logic [2:0]    shot_next;
   logic [TMR_W-1:0] cnt_reg;
   logic [TMR_W-1:0] limit;
   logic [31:0]   pre_reg;
   logic          seq_tick;
   logic          restart;
   logic          tmr_done;
   logic          active_reg;
   logic [4:0]    step_reg;
   logic [4:0]    step_next;

   // Event detection
   logic [N_SRC-1:0] src_trip;
   logic [N_SRC-1:0] init_vec;
   logic [N_SRC-1:0] blk_vec;
   logic             tick;
   logic             ext_any;
   logic             init_lvl;
   logic             fault_lvl;
   logic             coord_lvl;
   logic             prev_init_reg;
   logic             prev_fault_reg;
   logic             prev_man_reg;
   logic             prev_rst_reg;
   logic             init_rise;
   logic             fault_rise;
   logic             man_rise;
   logic             reset_all;
   logic             blk_hit;
   logic             arm_ok;
   logic [2:0]       num_sel;
   logic [DW-1:0]    rd_mux;

   // Named pins after synchronisation
   logic ext3_s;
   logic extp_any_s;
   logic block_s;
   logic bready_s;
   logic bclosed_s;
   logic mclose_s;
   logic rkey_s;
   logic rrem_s;

   assign pin_raw = {ext_phase_trip, external_three_phase_trip, reclose_block_input,
                     breaker_ready, breaker_closed, manual_close, reset_key, remote_reset};

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pin_m_reg <= '0;
         pin_s_reg <= '0;
      end
      else
      begin
         pin_m_reg <= pin_raw;
         pin_s_reg <= pin_m_reg;
      end
   end

   assign extp_any_s = |pin_s_reg[9:7];
   assign ext3_s     = pin_s_reg[6];
   assign block_s    = pin_s_reg[5];
   assign bready_s   = pin_s_reg[4];
   assign bclosed_s  = pin_s_reg[3];
   assign mclose_s   = pin_s_reg[2];
   assign rkey_s     = pin_s_reg[1];
   assign rrem_s     = pin_s_reg[0];

   arc_tick_gen #(
      .CYCLES (TICK_CYC)
   ) u_tick (
      .clk_sys (clk_sys),
      .rst     (rst),
      .tick    (tick)
   );

   // Trip sources: protection elements, then external trips
   assign ext_any  = extp_any_s | ext3_s;
   assign src_trip = {ext_any, prot_trip};

   genvar gi;
   generate
      for (gi = 0; gi < N_SRC; gi++)
      begin : g_src
         logic [1:0] sel;
         assign sel          = init_reg[2*gi+1:2*gi];
         assign init_vec[gi] = src_trip[gi] && (sel == SEL_A1 || sel == SEL_A2);
         assign blk_vec[gi]  = src_trip[gi] && (sel == SEL_BLK);
      end
   endgenerate

   // Coordination: fault current seen by an enabled element type
   assign coord_lvl = (phase_over && ctrl_reg[CTRL_CO_PH])
                    | (earth_over && ctrl_reg[CTRL_CO_EF])
                    | (sens_earth_over && ctrl_reg[CTRL_CO_SE]);

   assign init_lvl  = (|init_vec) | coord_lvl;
   assign fault_lvl = (|src_trip) | coord_lvl;
   assign blk_hit   = (|blk_vec) | (block_s && fault_lvl);
   assign arm_ok    = bready_s && bclosed_s && ctrl_reg[CTRL_EN] && !block_s;
   assign num_sel   = (ctrl_reg[CTRL_NUM_LSB+2:CTRL_NUM_LSB] > NUM_MAX)
                    ? NUM_MAX : ctrl_reg[CTRL_NUM_LSB+2:CTRL_NUM_LSB];

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         prev_init_reg  <= 1'b0;
         prev_fault_reg <= 1'b0;
         prev_man_reg   <= 1'b0;
         prev_rst_reg   <= 1'b0;
      end
      else
      begin
         prev_init_reg  <= init_lvl;
         prev_fault_reg <= fault_lvl;
         prev_man_reg   <= mclose_s;
         prev_rst_reg   <= rkey_s | rrem_s;
      end
   end

   assign init_rise  = init_lvl && !prev_init_reg;
   assign fault_rise = fault_lvl && !prev_fault_reg;
   assign man_rise   = mclose_s && !prev_man_reg;
   assign reset_all  = (rkey_s | rrem_s) && !prev_rst_reg;

   // Timer limit for the current state
   always_comb
   begin
      case (st_reg)
         ST_IDLE:   limit = tmr_reg[T_RECLAIM];
         ST_DEAD:   limit = tmr_reg[T_DEAD1 + 32'(shot_reg)];
         ST_PULSE:  limit = tmr_reg[T_PULSE];
         ST_JUDGE:  limit = tmr_reg[T_SUCC];
         ST_SRESET: limit = tmr_reg[T_SRESET];
         ST_FINAL:  limit = tmr_reg[T_RECOV];
         ST_PAUSE:  limit = tmr_reg[T_PAUSE];
         default:   limit = '0;
      endcase
   end

   assign tmr_done = (cnt_reg >= limit);

   always_comb
   begin
      st_next   = st_reg;
      shot_next = shot_reg;
      case (st_reg)
         ST_IDLE:
            if (man_rise)
               st_next = ST_PAUSE;
            else if (fault_rise)
               st_next = ST_FINAL;
            else if (arm_ok && tmr_done)
               st_next = ST_READY;
         ST_READY:
            if (!arm_ok)
               st_next = ST_IDLE;
            else if (man_rise)
               st_next = ST_PAUSE;
            else if (blk_hit)
               st_next = ST_FINAL;
            else if (init_rise)
            begin
               st_next   = ST_DEAD;
               shot_next = 3'h0;
            end
         ST_DEAD:
            if (blk_hit || !ctrl_reg[CTRL_EN] || block_s)
               st_next = ST_FINAL;
            else if (tmr_done)
               st_next = ST_PULSE;
         ST_PULSE:
            if (tmr_done)
               st_next = ST_JUDGE;
         ST_JUDGE:
            if (blk_hit)
               st_next = ST_FINAL;
            else if (init_rise && shot_reg < num_sel)
            begin
               st_next   = ST_DEAD;
               shot_next = shot_reg + 3'h1;
            end
            else if (init_rise)
               st_next = ST_FINAL;
            else if (tmr_done)
               st_next = ST_SRESET;
         ST_SRESET:
            if (fault_rise)
               st_next = ST_FINAL;
            else if (tmr_done)
               st_next = ST_IDLE;
         ST_FINAL:
            if (tmr_done)
               st_next = ST_IDLE;
         ST_PAUSE:
            if (tmr_done)
               st_next = ST_IDLE;
         default:
            st_next = ST_IDLE;
      endcase
   end

   // Reclaim restarts whenever the arming conditions drop
   assign restart = (st_next != st_reg) || (st_reg == ST_IDLE && !arm_ok);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st_reg   <= ST_IDLE;
         shot_reg <= 3'h0;
      end
      else
      begin
         st_reg   <= st_next;
         shot_reg <= shot_next;
      end
   end

   // Each sequencer state timer restarts its own tick phase, so delays are whole ticks
   always_ff @(posedge clk_sys)
   begin
      if (rst || restart)
         pre_reg <= 32'h1;
      else if (seq_tick)
         pre_reg <= 32'h0;
      else
         pre_reg <= pre_reg + 32'h1;
   end

   assign seq_tick = (pre_reg >= 32'(TICK_CYC - 1));

   always_ff @(posedge clk_sys)
   begin
      if (rst || restart)
         cnt_reg <= '0;
      else if (seq_tick && !tmr_done)
         cnt_reg <= cnt_reg + 16'h1;
   end

   // Activation latch holds from initiation until the cycle ends
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         active_reg <= 1'b0;
      else if (st_reg == ST_READY && st_next == ST_DEAD)
         active_reg <= 1'b1;
      else if (st_next == ST_IDLE || st_next == ST_FINAL)
         active_reg <= 1'b0;
   end

   always_comb
   begin
      step_next = 5'h00;
      if (st_next == ST_DEAD || st_next == ST_PULSE || st_next == ST_JUDGE)
      begin
         case (shot_next)
            3'h1:    step_next = 5'h01;
            3'h2:    step_next = 5'h02;
            3'h3:    step_next = 5'h04;
            3'h4:    step_next = 5'h08;
            default: step_next = 5'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         reclose_command <= 1'b0;
         final_trip_flag <= 1'b0;
         reclose_ready   <= 1'b0;
         step_reg        <= 5'h00;
      end
      else
      begin
         reclose_command <= (st_next == ST_PULSE);
         final_trip_flag <= (st_next == ST_FINAL);
         reclose_ready   <= (st_next == ST_READY);
         step_reg        <= step_next;
      end
   end

   assign step_bit_one   = step_reg[0];
   assign step_bit_two   = step_reg[1];
   assign step_bit_three = step_reg[2];
   assign step_bit_four  = step_reg[3];
   assign step_bit_five  = step_reg[4];

   // Output relays
   generate
      for (gi = 0; gi < N_RLY; gi++)
      begin : g_rly
         arc_out_relay u_rly (
            .clk_sys    (clk_sys),
            .rst        (rst),
            .tick       (tick),
            .drive      (relay_drive[gi]),
            .latch_en   (latch_reg[gi]),
            .reset_all  (reset_all),
            .reset_time (rly_reg[gi]),
            .relay_on   (relay_out[gi])
         );

         always_ff @(posedge clk_sys)
         begin
            if (rst)
               rly_reg[gi] <= RLY_DEF;
            else if (reg_wr && reg_addr == 8'(OFS_RLY + 4*gi))
               rly_reg[gi] <= reg_wdata[TMR_W-1:0];
         end
      end

      for (gi = 0; gi < N_TMR; gi++)
      begin : g_tmr
         always_ff @(posedge clk_sys)
         begin
            if (rst)
               tmr_reg[gi] <= TMR_DEF[gi];
            else if (reg_wr && reg_addr == 8'(OFS_TMR + 4*gi))
               tmr_reg[gi] <= reg_wdata[TMR_W-1:0];
         end
      end
   endgenerate

   // Control registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ctrl_reg  <= CTRL_RST;
         init_reg  <= INIT_RST;
         latch_reg <= LATCH_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == OFS_CTRL)
            ctrl_reg <= {25'h0, reg_wdata[6:0]};
         if (reg_addr == OFS_INIT)
            init_reg <= {6'h0, reg_wdata[25:0]};
         if (reg_addr == OFS_LATCH)
            latch_reg <= {25'h0, reg_wdata[6:0]};
      end
   end

   // Read path, unmapped addresses read zero
   always_comb
   begin
      rd_mux = '0;
      case (reg_addr)
         OFS_CTRL:  rd_mux = ctrl_reg;
         OFS_INIT:  rd_mux = init_reg;
         OFS_LATCH: rd_mux = latch_reg;
         OFS_STAT:  rd_mux = {21'h0, shot_reg, active_reg, reclose_ready,
                              final_trip_flag, step_reg};
         default:   rd_mux = '0;
      endcase
      for (int i = 0; i < N_TMR; i++)
         if (reg_addr == 8'(OFS_TMR + 4*i))
            rd_mux = {16'h0, tmr_reg[i]};
      for (int i = 0; i < N_RLY; i++)
         if (reg_addr == 8'(OFS_RLY + 4*i))
            rd_mux = {16'h0, rly_reg[i]};
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         reg_rdata <= '0;
      else if (reg_rd)
         reg_rdata <= rd_mux;
      else
         reg_rdata <= '0;
   end

endmodule : arc_sequencer

// ==== hw/arc_tick_gen.sv ====
// Purpose: Common timing tick for the output relay reset timers
// Assumes: CYCLES clk_sys periods per tick
// Notes:   tick is a one-cycle pulse
`timescale 1ns/1ps
module arc_tick_gen
   import arc_pkg::*;
#(
   parameter int CYCLES = TICK_CYCLES
)(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Tick
   output logic      tick
);

   logic [31:0] div_reg;

   always_ff @(posedge clk_sys)
   begin
      if (rst || div_reg == 32'(CYCLES - 1))
         div_reg <= 32'h0;
      else
         div_reg <= div_reg + 32'h1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         tick <= 1'b0;
      else
         tick <= (div_reg == 32'(CYCLES - 1));
   end

endmodule : arc_tick_gen

// ==== verif/arc_breaker_model.sv ====
// Purpose: Breaker model with trip coil, close coil and spring charge
// Assumes: Coils are driven from clk_sys logic
// Notes:   Ready drops while the spring recharges after a close
`timescale 1ns/1ps
module arc_breaker_model
#(
   parameter int RECHARGE = 6
)(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Coils
   input  wire logic trip_coil,
   input  wire logic close_coil,
   input  wire logic man_close,
   // Contacts
   output logic      breaker_closed,
   output logic      breaker_ready
);
   int chg_reg;
   always_ff @(posedge clk_sys)
      if (rst)
      begin
         breaker_closed <= 1'b1;
         chg_reg        <= 0;
      end
      else if (trip_coil)
         breaker_closed <= 1'b0;
      else if ((close_coil || man_close) && !breaker_closed)
      begin
         breaker_closed <= 1'b1;
         chg_reg        <= RECHARGE;
      end
      else if (chg_reg != 0)
         chg_reg <= chg_reg - 1;
   assign breaker_ready = (chg_reg == 0);
endmodule : arc_breaker_model

// ==== verif/arc_sequencer_asserts.sv ====
// Purpose: Port assertions for arc_sequencer
// Assumes: TICK_CYC equals the instance parameter
// Notes:   Attached by bind at the foot
`timescale 1ns/1ps
module arc_sequencer_chk
   import arc_pkg::*;
#(
   parameter int TICK_CYC = 10
)(
   // Clock and reset
   input wire logic             clk_sys,
   input wire logic             rst,
   // Watched ports
   input wire logic [N_RLY-1:0] relay_drive,
   input wire logic [N_RLY-1:0] relay_out,
   input wire logic             breaker_ready,
   input wire logic             reclose_command,
   input wire logic             final_trip_flag,
   input wire logic             step_bit_one,
   input wire logic             step_bit_two,
   input wire logic             step_bit_three,
   input wire logic             step_bit_four,
   input wire logic             step_bit_five,
   input wire logic             reclose_ready
);
   logic [4:0]  steps;
   logic [15:0] cmd_len_reg;
   assign steps = {step_bit_five, step_bit_four, step_bit_three, step_bit_two, step_bit_one};
   always_ff @(posedge clk_sys)
      if (rst)
         cmd_len_reg <= 16'h0;
      else
         cmd_len_reg <= reclose_command ? cmd_len_reg + 16'h1 : 16'h0;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   step_onehot_a: assert property ($onehot0(steps))
      else $error("step bits not one-hot");
   cmd_final_excl_a: assert property (!(reclose_command && final_trip_flag))
      else $error("reclose during final trip");
   ready_breaker_a: assert property (reclose_ready |-> $past(breaker_ready, 3) || $past(breaker_ready, 4))
      else $error("ready without breaker ready");
   pulse_tick_a: assert property ($fell(reclose_command) |-> cmd_len_reg != 0 && (cmd_len_reg % TICK_CYC) == 0)
      else $error("reclose pulse not whole ticks");
   single_pulse_a: assert property ($fell(reclose_command) |-> (!reclose_command) [*8])
      else $error("reclose pulse repeated");
   final_unready_a: assert property ($fell(final_trip_flag) |-> (!reclose_ready) [*8])
      else $error("ready right after recovery");
   reset_quiet_a: assert property ($past(rst) |-> relay_out == '0 && !reclose_command && steps == '0)
      else $error("outputs active after reset");
   relay_follow_a: assert property (relay_drive != '0 |=> (relay_out & $past(relay_drive)) == $past(relay_drive))
      else $error("relay not energised by drive");
   ready_idle_a: assert property (reclose_ready |-> steps == '0 && !final_trip_flag)
      else $error("ready while sequence active");
   cover property ($rose(reclose_command));
   cover property ($rose(final_trip_flag));
   cover property ($rose(step_bit_two));
endmodule : arc_sequencer_chk

bind arc_sequencer arc_sequencer_chk #(.TICK_CYC(TICK_CYC)) u_chk (.*);

// ==== verif/arc_sequencer_test.sv ====
// Purpose: Self-checking bench for arc_sequencer
// Assumes: Tick shortened to 10 clk_sys cycles
// Notes:   Breaker opens on relay 0, closes on reclose or manual close
`timescale 1ns/1ps
module arc_sequencer_test;
   import arc_pkg::*;
   localparam int TC = 10;
   logic              clk_sys, rst, reg_wr, reg_rd, phase_over, reset_key, manual_close;
   logic              external_three_phase_trip, reclose_block_input, breaker_ready;
   logic              breaker_closed, reclose_command, final_trip_flag, reclose_ready, cmd_q;
   logic              step_bit_one, step_bit_two, step_bit_three, step_bit_four, step_bit_five;
   logic [AW-1:0]     reg_addr;
   logic [DW-1:0]     reg_wdata, reg_rdata;
   logic [N_PROT-1:0] prot_trip;
   logic [N_RLY-1:0]  relay_drive, relay_out;
   logic [4:0]        w;
   logic [31:0]       seed;
   logic [15:0]       tv [N_TMR];
   int                fail_count, n_tests, cyc, n_shots, exp_shots, n, rt, d;
   int                dead_q [$];

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   arc_sequencer #(.TICK_CYC(TC)) u_dut (.*, .earth_over(1'b0), .sens_earth_over(1'b0),
      .ext_phase_trip(3'h0), .remote_reset(1'b0));

   arc_breaker_model u_brk (
      .clk_sys(clk_sys), .rst(rst), .trip_coil(relay_out[0]), .close_coil(reclose_command),
      .man_close(manual_close), .breaker_closed(breaker_closed),
      .breaker_ready(breaker_ready));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   assign w = {relay_out[2:1], reclose_ready, final_trip_flag, reclose_command};

   task automatic tally_and_finish();
      if (fail_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rng(input int v, input int lo, input int hi);
      chk(32'(v >= lo && v <= hi), 32'h1);
   endtask : rng

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask : rd

   // Waits for watched output s to reach v; k counts edges
   task automatic wait_sig(input int s, input logic v, output int k);
      k = 0;
      do
      begin
         @(posedge clk_sys);
         #1;
         k++;
      end while (w[s] !== v && k < 3000);
   endtask : wait_sig

   task automatic trip(input int src);
      @(posedge clk_sys);
      relay_drive[0] <= 1'b1;
      case (src)
         0: prot_trip[0] <= 1'b1;
         1: external_three_phase_trip <= 1'b1;
         2: phase_over <= 1'b1;
         default: prot_trip[1] <= 1'b1;
      endcase
      repeat (3) @(posedge clk_sys);
      relay_drive[0]            <= 1'b0;
      prot_trip                 <= '0;
      external_three_phase_trip <= 1'b0;
      phase_over                <= 1'b0;
   endtask : trip

   task automatic man_close();
      @(posedge clk_sys);
      manual_close <= 1'b1;
      repeat (2) @(posedge clk_sys);
      manual_close <= 1'b0;
   endtask : man_close

   always @(posedge clk_sys)
   begin
      cmd_q <= reclose_command;
      cyc   <= cyc + 1;
      if (reclose_command && !cmd_q)
         n_shots <= n_shots + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end

   initial
   begin
      rst = 1'b1;
      {reg_wr, reg_rd, phase_over, reset_key, manual_close, cmd_q, reg_addr, reg_wdata,
       external_three_phase_trip, reclose_block_input, prot_trip, relay_drive} = '0;
      seed = 32'h7d14;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      rd(OFS_CTRL, CTRL_RST);
      rd(OFS_INIT, INIT_RST);
      rd(OFS_STAT, 32'h0);
      rd(8'hfc, 32'h0);
      rd(OFS_TMR + 8'h4, 32'(TMR_DEF[T_DEAD1]));
      tv = '{16'h6, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h2, 16'h3, 16'h4, 16'h3, 16'h2};
      for (int i = 1; i < 6; i++)
      begin
         seed = lfsr(seed);
         tv[i] = 16'(2 + seed % 4);
         dead_q.push_back(int'(tv[i]));
      end
      for (int i = 0; i < N_TMR; i++)
         wr(OFS_TMR + 8'(4 * i), 32'(tv[i]));
      rd(OFS_TMR + 8'h4, 32'(tv[1]));
      wr(OFS_CTRL, 32'h15);
      wr(OFS_INIT, 32'h0100_000d);
      wr(OFS_LATCH, 32'h4);
      seed = lfsr(seed);
      rt = 1 + seed % 4;
      wr(OFS_RLY + 8'h4, 32'(rt));
      @(posedge clk_sys);
      relay_drive[2:1] <= 2'h3;
      repeat (3) @(posedge clk_sys);
      relay_drive[2:1] <= 2'h0;
      wait_sig(3, 1'b0, n);
      rng(n, (rt - 1) * TC, rt * TC + 2);
      chk(relay_out[2], 1'b1);
      @(posedge clk_sys);
      reset_key <= 1'b1;
      repeat (3) @(posedge clk_sys);
      reset_key <= 1'b0;
      wait_sig(4, 1'b0, n);
      rng(n, 1, 8);
      wait_sig(2, 1'b1, n);
      chk(reclose_ready, 1'b1);
      for (int s = 0; s < 4; s++)
      begin
         trip(s % 3);
         if (s < 3)
         begin
            d = dead_q.pop_front();
            wait_sig(0, 1'b1, n);
            rng(n + 3, (d - 1) * TC, d * TC + 12);
            chk({step_bit_five, step_bit_four, step_bit_three, step_bit_two, step_bit_one},
                s == 0 ? 32'h0 : 32'(1 << (s - 1)));
            exp_shots++;
            wait_sig(0, 1'b0, n);
            chk(n, tv[T_PULSE] * TC);
         end
      end
      wait_sig(1, 1'b1, n);
      rng(n, 1, 25);
      wait_sig(1, 1'b0, n);
      rng(n, (tv[T_RECOV] - 1) * TC, tv[T_RECOV] * TC + 2);
      chk(n_shots, exp_shots);
      for (int k = 0; k < 3; k++)
      begin
         man_close();
         if (k < 2)
            wait_sig(2, 1'b1, n);
         else
            repeat (45) @(posedge clk_sys);
         if (k == 0)
         begin
            rng(n, tv[T_PAUSE] * TC, 3000);
            @(posedge clk_sys);
            reclose_block_input <= 1'b1;
            repeat (4) @(posedge clk_sys);
         end
         trip(k == 1 ? 3 : 0);
         wait_sig(1, 1'b1, n);
         rng(n, 1, 25);
         @(posedge clk_sys);
         reclose_block_input <= 1'b0;
         wait_sig(1, 1'b0, n);
         chk(n_shots, exp_shots);
      end
      wr(OFS_CTRL, 32'h0);
      man_close();
      repeat (150) @(posedge clk_sys);
      chk(reclose_ready, 1'b0);
      tally_and_finish();
   end
endmodule : arc_sequencer_test
